// File: core/sequencer_pkg.sv
// Shared constants and types for the front-end instruction sequencer.
// Assumes one system clock and a flip-flop instruction store.
package sequencer_pkg;
    localparam int STORE_DEPTH = 4096;
    localparam int WORD_W = 22;
    localparam int ADDR_W = 12;
    localparam int PARAM_W = 20;
    localparam int CLASS_HI = 21;
    localparam int CLASS_LO = 20;
    localparam int OPC_HI = 19;
    localparam int OPC_LO = 16;
    localparam int ARG_W = 16;
    localparam int LOOP_CNT_HI = 15;
    localparam int LOOP_CNT_LO = 12;
    localparam int LOOP_RET_HI = 11;
    localparam int LOOP_RET_LO = 0;
    localparam int LOOP_CNT_W = 4;

    localparam logic [1:0] CLASS_FE_READ = 2'h0;
    localparam logic [1:0] CLASS_FE_COMMAND = 2'h1;
    localparam logic [1:0] CLASS_FE_WRITE = 2'h2;
    localparam logic [1:0] CLASS_INTERNAL = 2'h3;

    localparam logic [3:0] OPC_LOOP = 4'h1;
    localparam logic [3:0] OPC_WAIT = 4'h2;
    localparam logic [3:0] OPC_END_OF_SEQUENCE = 4'h8;
    localparam logic [3:0] OPC_END_OF_STORE = 4'hF;

    localparam logic [ADDR_W-1:0] PC_RESET = 12'h000;
    localparam logic [ADDR_W-1:0] PC_LAST = 12'hFFF;
    localparam logic [ADDR_W-1:0] PC_STEP = 12'h001;
    localparam logic [ARG_W-1:0] WAIT_STEP = 16'h0001;
    localparam logic [LOOP_CNT_W-1:0] LOOP_STEP = 4'h1;
    localparam logic [LOOP_CNT_W-1:0] LOOP_NONE = 4'h0;

    typedef struct packed {
        logic valid;
        logic [1:0] kind;
        logic [PARAM_W-1:0] addr;
        logic [PARAM_W-1:0] data;
    } fe_req_t;

    typedef struct packed {
        logic en;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } store_wr_t;
endpackage : sequencer_pkg

// File: core/instruction_store.sv
// Instruction store: flip-flop array, synchronous write, registered read.
// Assumes the sequencer presents its read index one cycle before use.
`timescale 1ns/1ps
module instruction_store
    import sequencer_pkg::*;
#(
    parameter int DEPTH = STORE_DEPTH,
    parameter int W = WORD_W
) (
    input wire logic ref_clk_in,
    input wire logic wr_en_in,
    input wire logic [ADDR_W-1:0] wr_addr_in,
    input wire logic [W-1:0] wr_data_in,
    input wire logic [ADDR_W-1:0] rd_addr_in,
    output logic [W-1:0] rd_data_out
);
    logic [W-1:0] mem_r [DEPTH];

    // No reset on storage: contents are software preloaded
    always_ff @(posedge ref_clk_in) begin
        if (wr_en_in) begin
            mem_r[wr_addr_in] <= wr_data_in;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        rd_data_out <= mem_r[rd_addr_in];
    end
endmodule : instruction_store

// File: core/instruction_sequencer.sv
// Front-end instruction sequencer: fetches preloaded words and issues them.
// Assumes front-end cards acknowledge each request with a done pulse.
`timescale 1ns/1ps
module instruction_sequencer
    import sequencer_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire store_wr_t store_wr_in,
    input wire logic start_in,
    input wire logic fe_done_in,
    output fe_req_t fe_req_out,
    output logic busy_out,
    output logic seq_done_out,
    output logic store_end_out,
    output logic illegal_out,
    output logic [ADDR_W-1:0] pc_out
);
    typedef enum logic [2:0] {
        S_IDLE,
        S_FETCH,
        S_DECODE,
        S_FETCH_DATA,
        S_LATCH_DATA,
        S_ISSUE,
        S_WAIT
    } seq_state_t;

    function automatic logic is_known_opcode(input logic [3:0] opc);
        is_known_opcode = (opc == OPC_LOOP) || (opc == OPC_WAIT) ||
            (opc == OPC_END_OF_SEQUENCE) || (opc == OPC_END_OF_STORE);
    endfunction : is_known_opcode

    seq_state_t state_r;
    seq_state_t state_nxt;
    logic [ADDR_W-1:0] pc_r;
    logic [ADDR_W-1:0] pc_nxt;
    logic [WORD_W-1:0] word;
    logic [1:0] word_class;
    logic [3:0] opcode;
    logic [ARG_W-1:0] arg;
    logic [LOOP_CNT_W-1:0] loop_cnt;
    logic [ADDR_W-1:0] loop_ret;
    logic [LOOP_CNT_W-1:0] jumps_left;
    logic loop_active_r;
    logic [LOOP_CNT_W-1:0] loop_left_r;
    logic [ARG_W-1:0] wait_cnt_r;
    logic [PARAM_W-1:0] wr_addr_r;
    logic decode_now;
    logic loop_jump;
    logic [ADDR_W-1:0] rd_index;

    instruction_store #(
        .DEPTH(STORE_DEPTH),
        .W(WORD_W)
    ) instruction_store_inst (
        .ref_clk_in(ref_clk_in),
        .wr_en_in(store_wr_in.en && !busy_out),
        .wr_addr_in(store_wr_in.addr),
        .wr_data_in(store_wr_in.data),
        .rd_addr_in(rd_index),
        .rd_data_out(word)
    );

    // Loads are refused while running so a sequence never sees half-new code
    assign rd_index = pc_r;
    assign word_class = word[CLASS_HI:CLASS_LO];
    assign opcode = word[OPC_HI:OPC_LO];
    assign arg = word[ARG_W-1:0];
    assign loop_cnt = word[LOOP_CNT_HI:LOOP_CNT_LO];
    assign loop_ret = word[LOOP_RET_HI:LOOP_RET_LO];
    assign decode_now = (state_r == S_DECODE);
    // Count of N runs the block N times: N-1 jumps back; a count of 0 runs it once, like 1
    assign jumps_left = loop_active_r ? loop_left_r :
        ((loop_cnt == LOOP_NONE) ? LOOP_NONE : loop_cnt - LOOP_STEP);
    assign loop_jump = (jumps_left != LOOP_NONE);

    always_comb begin
        state_nxt = state_r;
        pc_nxt = pc_r;
        case (state_r)
            S_IDLE: begin
                if (start_in) begin
                    state_nxt = S_FETCH;
                    pc_nxt = PC_RESET;
                end
            end
            S_FETCH: begin
                state_nxt = S_DECODE;
            end
            S_DECODE: begin
                pc_nxt = pc_r + PC_STEP;
                state_nxt = S_FETCH;
                case (word_class)
                    CLASS_FE_READ, CLASS_FE_COMMAND: begin
                        state_nxt = S_ISSUE;
                    end
                    CLASS_FE_WRITE: begin
                        state_nxt = S_FETCH_DATA;
                    end
                    default: begin
                        case (opcode)
                            OPC_LOOP: begin
                                if (loop_jump) begin
                                    pc_nxt = loop_ret;
                                end
                            end
                            OPC_WAIT: begin
                                if (arg != '0) begin
                                    state_nxt = S_WAIT;
                                end
                            end
                            OPC_END_OF_SEQUENCE: begin
                                state_nxt = S_IDLE;
                                pc_nxt = pc_r;
                            end
                            OPC_END_OF_STORE: begin
                                state_nxt = S_IDLE;
                                pc_nxt = pc_r;
                            end
                            default: begin
                                state_nxt = S_FETCH;
                            end
                        endcase
                    end
                endcase
                // An internal word at the last index whose next step is a fetch of word zero stops like an end of store
                if (pc_r == PC_LAST && state_nxt == S_FETCH && pc_nxt == PC_RESET) begin
                    state_nxt = S_IDLE;
                    pc_nxt = pc_r;
                end
            end
            S_FETCH_DATA: begin
                state_nxt = S_LATCH_DATA;
            end
            S_LATCH_DATA: begin
                pc_nxt = pc_r + PC_STEP;
                state_nxt = S_ISSUE;
            end
            S_ISSUE: begin
                if (fe_done_in) begin
                    state_nxt = (pc_r == PC_RESET) ? S_IDLE : S_FETCH;
                end
            end
            S_WAIT: begin
                if (wait_cnt_r == WAIT_STEP) begin
                    state_nxt = S_FETCH;
                end
            end
            default: begin
                state_nxt = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= S_IDLE;
            pc_r <= PC_RESET;
        end else begin
            state_r <= state_nxt;
            pc_r <= pc_nxt;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            loop_active_r <= 1'b0;
            loop_left_r <= LOOP_NONE;
        end else if (state_r == S_IDLE) begin
            loop_active_r <= 1'b0;
            loop_left_r <= LOOP_NONE;
        end else if (decode_now && word_class == CLASS_INTERNAL && opcode == OPC_LOOP) begin
            loop_active_r <= loop_jump;
            loop_left_r <= loop_jump ? jumps_left - LOOP_STEP : LOOP_NONE;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wait_cnt_r <= '0;
        end else if (decode_now && word_class == CLASS_INTERNAL && opcode == OPC_WAIT) begin
            wait_cnt_r <= arg;
        end else if (state_r == S_WAIT) begin
            wait_cnt_r <= wait_cnt_r - WAIT_STEP;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            fe_req_out <= '0;
            wr_addr_r <= '0;
        end else if (decode_now && word_class != CLASS_INTERNAL) begin
            wr_addr_r <= word[PARAM_W-1:0];
            fe_req_out.kind <= word_class;
            fe_req_out.addr <= word[PARAM_W-1:0];
            fe_req_out.data <= '0;
            fe_req_out.valid <= (word_class != CLASS_FE_WRITE);
        end else if (state_r == S_LATCH_DATA) begin
            fe_req_out.addr <= wr_addr_r;
            fe_req_out.data <= word[PARAM_W-1:0];
            fe_req_out.valid <= 1'b1;
        end else if (state_r == S_ISSUE && fe_done_in) begin
            fe_req_out.valid <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            busy_out <= 1'b0;
            seq_done_out <= 1'b0;
            store_end_out <= 1'b0;
            illegal_out <= 1'b0;
            pc_out <= PC_RESET;
        end else begin
            busy_out <= (state_nxt != S_IDLE);
            pc_out <= pc_nxt;
            seq_done_out <= decode_now && word_class == CLASS_INTERNAL &&
                opcode == OPC_END_OF_SEQUENCE;
            // Wrap after an issued request also counts as leaving the store
            store_end_out <= (decode_now && state_nxt == S_IDLE &&
                !(word_class == CLASS_INTERNAL && opcode == OPC_END_OF_SEQUENCE)) ||
                (state_r == S_ISSUE && fe_done_in && pc_r == PC_RESET);
            illegal_out <= decode_now && word_class == CLASS_INTERNAL &&
                !is_known_opcode(opcode);
        end
    end

    chk_req_hold: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        fe_req_out.valid && !fe_done_in |=> fe_req_out.valid && $stable(fe_req_out))
        else $error("front-end request dropped before done");
    chk_start_runs: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        state_r == S_IDLE && start_in |=> busy_out && pc_r == PC_RESET ##1 state_r == S_DECODE)
        else $error("start did not begin a run at word zero");
    chk_wait_stall: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        decode_now && word_class == CLASS_INTERNAL && opcode == OPC_WAIT && arg == 16'h0005
        |=> state_r == S_WAIT [*5] ##1 state_r == S_FETCH)
        else $error("wait stalled the wrong number of cycles");
    chk_seq_end: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        decode_now && word_class == CLASS_INTERNAL && opcode == OPC_END_OF_SEQUENCE
        |=> seq_done_out && !busy_out && state_r == S_IDLE)
        else $error("end of sequence did not stop the run");
    chk_store_end: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        decode_now && word_class == CLASS_INTERNAL && opcode == OPC_END_OF_STORE
        |=> store_end_out && state_r == S_IDLE && !fe_req_out.valid)
        else $error("end of store did not stop the run");
    chk_loop_jump: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        decode_now && word_class == CLASS_INTERNAL && opcode == OPC_LOOP && !loop_active_r &&
        loop_cnt > LOOP_STEP |=> pc_r == $past(loop_ret) && loop_active_r)
        else $error("loop did not return to its address");
    chk_write_pair: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        $rose(fe_req_out.valid) && fe_req_out.kind == CLASS_FE_WRITE
        |-> $past(state_r) == S_LATCH_DATA && fe_req_out.addr == $past(wr_addr_r))
        else $error("write issued before both words were read");
    chk_illegal_skip: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        decode_now && word_class == CLASS_INTERNAL && !is_known_opcode(opcode)
        |=> illegal_out && !fe_req_out.valid && state_r == S_FETCH)
        else $error("unknown internal code was not skipped");
    chk_class_issue: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        decode_now && word_class == CLASS_FE_COMMAND
        |=> fe_req_out.valid && fe_req_out.kind == CLASS_FE_COMMAND)
        else $error("command word not issued as command");
    chk_read_issue: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        decode_now && word_class == CLASS_FE_READ |=> fe_req_out.valid &&
        fe_req_out.addr == $past(word[PARAM_W-1:0]) && fe_req_out.data == '0)
        else $error("read word not issued with its address");
    chk_write_order: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        decode_now && word_class == CLASS_FE_WRITE |=> !fe_req_out.valid ##1 !fe_req_out.valid
        ##1 fe_req_out.valid && fe_req_out.kind == CLASS_FE_WRITE)
        else $error("write issued before its data word");
    chk_end_pc: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        decode_now && word_class == CLASS_INTERNAL && opcode == OPC_END_OF_SEQUENCE
        |=> pc_out == $past(pc_r))
        else $error("end of sequence moved the word index");
    chk_idle_quiet: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        state_r == S_IDLE |-> !fe_req_out.valid)
        else $error("request pending while idle");

    cov_write: cover property (@(posedge ref_clk_in) disable iff (rst_in)
        fe_req_out.valid && fe_req_out.kind == CLASS_FE_WRITE && fe_done_in);
    cov_loop: cover property (@(posedge ref_clk_in) disable iff (rst_in)
        loop_active_r ##1 !loop_active_r);
    cov_wait: cover property (@(posedge ref_clk_in) disable iff (rst_in)
        state_r == S_WAIT ##1 state_r == S_FETCH);
    cov_seq_end: cover property (@(posedge ref_clk_in) disable iff (rst_in) seq_done_out);
    cov_store_end: cover property (@(posedge ref_clk_in) disable iff (rst_in) store_end_out);
endmodule : instruction_sequencer

// File: tb/front_end_card_model.sv
// Behavioural front-end card: answers each request with one done pulse.
// Assumes requests are held valid until the done pulse is seen.
`timescale 1ns/1ps
module front_end_card_model
    import sequencer_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire fe_req_t fe_req_in,
    input wire logic [3:0] delay_in,
    output logic fe_done_out
);
    logic [3:0] wait_r;

    // Done never in the cycle valid rises: it is registered off a seen valid
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            fe_done_out <= 1'b0;
            wait_r <= 4'h0;
        end else begin
            fe_done_out <= 1'b0;
            if (fe_req_in.valid && !fe_done_out) begin
                if (wait_r == delay_in) begin
                    fe_done_out <= 1'b1;
                    wait_r <= 4'h0;
                end else begin
                    wait_r <= wait_r + 4'h1;
                end
            end else begin
                wait_r <= 4'h0;
            end
        end
    end
endmodule : front_end_card_model

// File: tb/tb_instruction_sequencer.sv
// Self-checking bench for the instruction sequencer.
// Assumes the front-end card model answers every request.
`timescale 1ns/1ps
module tb_instruction_sequencer;
    import sequencer_pkg::*;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    store_wr_t store_wr = '0;
    logic start = 1'b0;
    logic fe_done;
    fe_req_t fe_req;
    logic busy, seq_done, store_end, illegal;
    logic [ADDR_W-1:0] pc;
    logic [3:0] dly_r = 4'h0;
    logic [41:0] reqs[$];
    logic [41:0] exp_req[6];
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int seq_n = 0, end_n = 0, ill_n = 0;
    int t_slow, t_fast, t3;

    always #2 ref_clk_in = ~ref_clk_in;

    instruction_sequencer instruction_sequencer_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .store_wr_in(store_wr), .start_in(start), .fe_done_in(fe_done), .fe_req_out(fe_req),
        .busy_out(busy), .seq_done_out(seq_done), .store_end_out(store_end),
        .illegal_out(illegal), .pc_out(pc));
    front_end_card_model front_end_card_model_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .fe_req_in(fe_req), .delay_in(dly_r), .fe_done_out(fe_done));

    task automatic chk(input logic [41:0] got, input logic [41:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    task automatic load(input logic [11:0] a, input logic [21:0] d);
        @(posedge ref_clk_in) store_wr <= '{1'b1, a, d};
        @(posedge ref_clk_in) store_wr.en <= 1'b0;
    endtask : load

    // Poke writes the loop body while running; it must be dropped
    task automatic run_prog(input logic [3:0] dly, input bit poke, output int cyc);
        reqs.delete();
        cyc = 0;
        @(posedge ref_clk_in) begin
            start <= 1'b1;
            dly_r <= dly;
        end
        @(posedge ref_clk_in) begin
            start <= 1'b0;
            if (poke) store_wr <= '{1'b1, 12'h006, 22'h38_0000};
        end
        @(posedge ref_clk_in) store_wr.en <= 1'b0;
        while (!(seq_done === 1'b1 || store_end === 1'b1) && cyc < 2000) begin
            @(negedge ref_clk_in);
            cyc++;
        end
        repeat (3) @(negedge ref_clk_in);
        if (cyc >= 2000) begin
            bad_count++;
            $display("BAD t=%0t run did not end", $time);
            end_sim();
        end
    endtask : run_prog

    task automatic check_reqs();
        chk(42'(reqs.size()), 42'd6, "request count");
        foreach (exp_req[i]) begin
            if (i < reqs.size()) chk(reqs[i], exp_req[i], "request");
        end
    endtask : check_reqs

    always @(posedge ref_clk_in) begin
        if (fe_req.valid && fe_done) reqs.push_back({fe_req.kind, fe_req.addr, fe_req.data});
        if (seq_done) seq_n++;
        if (store_end) end_n++;
        if (illegal) ill_n++;
        if (seq_done || store_end) chk(42'(busy), 42'd0, "busy after end");
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            $display("BAD t=%0t run hung", $time);
            end_sim();
        end
    end

    initial begin
        exp_req[0] = {2'h0, 20'h1_2345, 20'h0_0000};
        exp_req[1] = {2'h1, 20'h0_ABCD, 20'h0_0000};
        exp_req[2] = {2'h2, 20'h0_0077, 20'h5_5AA5};
        for (int i = 3; i < 6; i++) exp_req[i] = {2'h0, 20'h0_0001, 20'h0_0000};
        repeat (6) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        // Program: read, command, write pair, wait, bad code, looped read, end
        load(12'h000, 22'h01_2345);
        load(12'h001, 22'h10_ABCD);
        load(12'h002, 22'h20_0077);
        load(12'h003, 22'h35_5AA5);
        load(12'h004, 22'h32_0005);
        load(12'h005, 22'h33_0000);
        load(12'h006, 22'h00_0001);
        load(12'h007, 22'h31_3006);
        load(12'h008, 22'h38_0000);
        run_prog(4'h2, 1'b0, t_slow);
        check_reqs();
        chk(42'(seq_n), 42'd1, "sequence end pulses");
        chk(42'(ill_n), 42'd1, "illegal pulses");
        chk(42'(pc), 42'h008, "pc at end word");
        // Same program without the stall: run shortens by exactly the wait count
        load(12'h004, 22'h32_0000);
        run_prog(4'h2, 1'b0, t_fast);
        chk(42'(t_slow - t_fast), 42'd5, "wait length");
        check_reqs();
        // End of store, zero-delay front end, write while busy must be dropped
        load(12'h008, 22'h3F_0000);
        run_prog(4'h0, 1'b1, t3);
        check_reqs();
        chk(42'(end_n), 42'd1, "store end pulses");
        chk(42'(seq_n), 42'd2, "no extra sequence end");
        chk(42'(ill_n), 42'd3, "illegal pulses");
        chk(42'(busy), 42'd0, "idle after store end");
        chk(42'(pc), 42'h008, "pc at store end word");
        end_sim();
    end
endmodule : tb_instruction_sequencer
